// ==== logic/pic_pkg.sv ====
/*
 pic_pkg: constants shared by the sampled proportional-integral controller.
 assumes a 100 MHz system clock; value and output limits are signed integers in engineering units.
*/
package pic_pkg;
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned SAMPLE_MS      = 500;
   localparam int unsigned SAMPLE_CYCLES  = (CLK_HZ / 1000) * SAMPLE_MS;
   localparam int unsigned SAMPLE_MS_SEC  = 1000;
   localparam int          VAL_MIN        = -10000;
   localparam int          VAL_MAX        = 20000;
   localparam int          OUT_MIN        = 0;
   localparam int          OUT_MAX        = 1000;
   localparam int          MULT_LIM       = 1000;
   localparam int          OFFS_LIM       = 10000;
   localparam int          GAIN_MAX       = 9999;
   localparam int          FRAC_SCALE     = 100;
   localparam int          PER_MIN_S      = 1;
   localparam int          PER_MAX_S      = 5999;
   localparam int          SEC_PER_MIN    = 60;
   localparam int          SEC_FIELD_MAX  = 59;
   localparam int          FRAC_BITS      = 16;
   localparam logic [15:0] RESET_OUT      = 16'h0000;
   localparam logic        ACT_POSITIVE   = 1'b1;
   typedef enum logic [1:0] {PIC_IDLE, PIC_MANUAL, PIC_AUTO, PIC_HOLD} pic_state_t;
endpackage

// ==== logic/pic_sat.sv ====
/*
 pic_sat: registered saturating limiter for one signed value.
 assumes limits with lo not above hi; output is valid one clock after the input.
*/
`timescale 1ns/10ps
module pic_sat #(
   parameter int W = 48
) (
   input  wire logic                i_clk_sys,
   input  wire logic                i_resetn,
   input  wire logic signed [W-1:0] i_val,
   input  wire logic signed [W-1:0] i_lo,
   input  wire logic signed [W-1:0] i_hi,
   output logic signed [W-1:0]      o_val
);
   // select the bound that applies
   wire logic signed [W-1:0] sat_d = (i_val > i_hi) ? i_hi : ((i_val < i_lo) ? i_lo : i_val);

   // registered so downstream timing stays short
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_val <= '0;
      end else begin
         o_val <= sat_d;
      end
   end
endmodule // pic_sat

// ==== logic/pic_top.sv ====
/*
 pic_top: sampled proportional-integral controller with manual and automatic modes.
 assumes all parameter inputs are synchronous to i_clk_sys and held by neighbouring blocks.
*/
`timescale 1ns/10ps
module pic_top #(
   parameter int unsigned SAMPLE_CYCLES = pic_pkg::SAMPLE_CYCLES,
   parameter int          W             = 48
) (
   input  wire logic               i_clk_sys,
   input  wire logic               i_resetn,
   input  wire logic               i_auto_sel,
   input  wire logic               i_hold_low,
   input  wire logic signed [15:0] i_process_value,
   input  wire logic signed [15:0] i_setpoint,
   input  wire logic        [13:0] i_prop_gain,
   input  wire logic        [6:0]  i_period_min,
   input  wire logic        [5:0]  i_period_sec,
   input  wire logic               i_act_positive,
   input  wire logic        [15:0] i_manual_level,
   input  wire logic signed [15:0] i_pv_floor,
   input  wire logic signed [15:0] i_pv_ceiling,
   input  wire logic signed [11:0] i_pv_mult,
   input  wire logic signed [15:0] i_pv_offset,
   input  wire logic        [1:0]  i_decimals,
   output logic             [15:0] o_control_output,
   output logic                    o_sample,
   output logic                    o_running
);
   // working-width copies of the package limits
   localparam logic signed [W-1:0] S_ZERO  = '0;
   localparam logic signed [W-1:0] S_VMIN  = W'(pic_pkg::VAL_MIN);
   localparam logic signed [W-1:0] S_VMAX  = W'(pic_pkg::VAL_MAX);
   localparam logic signed [W-1:0] S_OMIN  = W'(pic_pkg::OUT_MIN);
   localparam logic signed [W-1:0] S_OMAX  = W'(pic_pkg::OUT_MAX);
   localparam logic signed [W-1:0] S_OMAXF = W'(pic_pkg::OUT_MAX) <<< pic_pkg::FRAC_BITS;
   localparam logic signed [W-1:0] S_FRAC  = W'(pic_pkg::FRAC_SCALE);
   localparam logic signed [W-1:0] S_MULT  = W'(pic_pkg::MULT_LIM);
   localparam logic signed [W-1:0] S_OFFS  = W'(pic_pkg::OFFS_LIM);
   localparam logic signed [W-1:0] S_GAIN  = W'(pic_pkg::GAIN_MAX);
   localparam logic signed [W-1:0] S_PMIN  = W'(pic_pkg::PER_MIN_S);
   localparam logic signed [W-1:0] S_PMAX  = W'(pic_pkg::PER_MAX_S);
   localparam logic signed [W-1:0] S_SPM   = W'(pic_pkg::SEC_PER_MIN);
   localparam logic signed [W-1:0] S_SECMX = W'(pic_pkg::SEC_FIELD_MAX);
   // sample period is a whole fraction of a second, so one divisor covers it
   localparam logic signed [W-1:0] S_TSDIV = W'(pic_pkg::SAMPLE_MS_SEC / pic_pkg::SAMPLE_MS);

   // tick counter width; a one-cycle period still needs one bit
   localparam int                  CW      = (SAMPLE_CYCLES > 1) ? $clog2(SAMPLE_CYCLES) : 1;
   localparam logic [CW-1:0]       CNT_TOP = CW'(SAMPLE_CYCLES - 1);

   // clamp a signed value into a range
   function automatic logic signed [W-1:0] lim(input logic signed [W-1:0] v,
                                               input logic signed [W-1:0] lo,
                                               input logic signed [W-1:0] hi);
      lim = (v > hi) ? hi : ((v < lo) ? lo : v);
   endfunction

   // sign-extend a 16-bit value to working width
   function automatic logic signed [W-1:0] sx(input logic signed [15:0] v);
      sx = W'(v);
   endfunction

   // zero-extend an unsigned 16-bit value to working width
   function automatic logic signed [W-1:0] ux(input logic [15:0] v);
      ux = W'({1'b0, v});
   endfunction

   // move an integer into the fixed-point accumulator format
   // fractional bits keep small integral steps from being lost each sample
   function automatic logic signed [W-1:0] fx(input logic signed [W-1:0] v);
      fx = v <<< pic_pkg::FRAC_BITS;
   endfunction

   // mode, tick and state registers
   pic_pkg::pic_state_t      state_q;
   pic_pkg::pic_state_t      state_d;
   pic_pkg::pic_state_t      mode_req;
   logic [CW-1:0]            cnt_q;
   logic [CW-1:0]            cnt_d;
   logic                     sample_q;
   logic                     run_q;
   logic                     act_q;

   // controller memory: accumulator, last error, output
   logic signed [W-1:0]      acc_q;
   logic signed [W-1:0]      acc_d;
   logic signed [W-1:0]      ep_q;
   logic signed [W-1:0]      ep_d;
   logic [15:0]              out_q;
   logic [15:0]              out_d;
   logic signed [W-1:0]      pv_work;

   // fixed sample tick
   // free-running so the interval never depends on mode changes
   wire logic tick = (cnt_q == CNT_TOP);
   assign cnt_d = tick ? '0 : cnt_q + CW'(1);

   wire logic hold_req = i_hold_low;
   wire logic auto_req = i_auto_sel && !hold_req;
   assign mode_req = hold_req ? pic_pkg::PIC_HOLD
                   : (auto_req ? pic_pkg::PIC_AUTO : pic_pkg::PIC_MANUAL);
   wire logic in_auto = (state_q == pic_pkg::PIC_AUTO);
   wire logic entry = (state_d == pic_pkg::PIC_AUTO) && !in_auto;

   wire logic signed [W-1:0] sp_lim  = lim(sx(i_setpoint), S_VMIN, S_VMAX);
   wire logic signed [W-1:0] kc_lim  = lim(ux(16'(i_prop_gain)), S_ZERO, S_GAIN);
   // period in seconds
   // a seconds field above its maximum is read as the maximum, not carried
   wire logic signed [W-1:0] sec_lim = lim(ux(16'(i_period_sec)), S_ZERO, S_SECMX);
   wire logic signed [W-1:0] ti_raw  = ux(16'(i_period_min)) * S_SPM + sec_lim;
   wire logic signed [W-1:0] ti_s    = lim(ti_raw, S_PMIN, S_PMAX);
   wire logic signed [W-1:0] man_lim = lim(ux(i_manual_level), S_OMIN, S_OMAX);
   wire logic signed [W-1:0] flo_lim = lim(sx(i_pv_floor), S_VMIN, S_VMAX);
   wire logic signed [W-1:0] cei_lim = lim(sx(i_pv_ceiling), S_VMIN, S_VMAX);
   wire logic signed [W-1:0] mul_lim = lim(W'(i_pv_mult), -S_MULT, S_MULT);
   wire logic signed [W-1:0] off_lim = lim(sx(i_pv_offset), -S_OFFS, S_OFFS);

   // decimal count unused
   // i_decimals only formats values for display, so no logic reads it here

   // scale raw input
   // multiplier is in hundredths; the quotient truncates toward zero
   wire logic signed [W-1:0] pv_scaled = (sx(i_process_value) * mul_lim) / S_FRAC + off_lim;

   // clamp working value
   // a floor set above the ceiling is not guarded against
   // one register of delay; each tick works on the scaled value from the clock before it
   pic_sat #(
      .W         (W)
   ) u_pv_clamp (
      .i_clk_sys (i_clk_sys),
      .i_resetn  (i_resetn),
      .i_val     (pv_scaled),
      .i_lo      (flo_lim),
      .i_hi      (cei_lim),
      .o_val     (pv_work)
   );

   wire logic act_eff = in_auto ? act_q : i_act_positive;

   wire logic signed [W-1:0] err_raw  = sp_lim - pv_work;
   wire logic signed [W-1:0] err      = (act_eff == pic_pkg::ACT_POSITIVE) ? err_raw : -err_raw;
   wire logic signed [W-1:0] err_step = err - ep_q;

   // zero gain drops proportional
   // integral keeps unity gain then, so the loop can still close
   wire logic signed [W-1:0] ki     = (kc_lim == S_ZERO) ? S_FRAC : kc_lim;
   wire logic signed [W-1:0] p_term = (kc_lim == S_ZERO) ? S_ZERO
                                    : fx(kc_lim * err_step) / S_FRAC;
   // incremental update terms
   // the divisor never reaches zero: the period is clamped to one second or more
   wire logic signed [W-1:0] i_term = (ti_s == S_PMAX) ? S_ZERO
                                    : fx(ki * err) / (S_FRAC * S_TSDIV * ti_s);
   wire logic signed [W-1:0] step     = (err == S_ZERO) ? S_ZERO : p_term + i_term;
   // saturate accumulator
   // clamping the sum itself stops windup beyond the output limits
   wire logic signed [W-1:0] acc_next = lim(acc_q + step, S_ZERO, S_OMAXF);
   wire logic        [15:0]  acc_out  = 16'(acc_next >>> pic_pkg::FRAC_BITS);

   // next state: every mode follows the request at once
   always_comb begin
      state_d = state_q;
      case (state_q)
         pic_pkg::PIC_IDLE: begin
            state_d = mode_req;
         end
         pic_pkg::PIC_MANUAL: begin
            state_d = mode_req;
         end
         pic_pkg::PIC_AUTO: begin
            state_d = mode_req;
         end
         pic_pkg::PIC_HOLD: begin
            state_d = mode_req;
         end
         default: begin
            state_d = pic_pkg::PIC_IDLE;
         end
      endcase
   end

   // next controller values by the mode being entered
   // manual keeps the last error fresh so entry starts without a kick
   always_comb begin
      out_d = out_q;
      acc_d = acc_q;
      ep_d  = ep_q;
      case (state_d)
         pic_pkg::PIC_IDLE: begin
            out_d = pic_pkg::RESET_OUT;
            acc_d = S_ZERO;
         end
         pic_pkg::PIC_HOLD: begin
            out_d = pic_pkg::RESET_OUT;
            acc_d = S_ZERO;
         end
         pic_pkg::PIC_MANUAL: begin
            out_d = man_lim[15:0];
            acc_d = fx(man_lim);
            ep_d  = err;
         end
         pic_pkg::PIC_AUTO: begin
            if (entry) begin
               out_d = man_lim[15:0];
               acc_d = fx(man_lim);
               ep_d  = err;
            end else if (tick) begin
               out_d = acc_out;
               acc_d = acc_next;
               ep_d  = err;
            end
         end
         default: begin
            out_d = pic_pkg::RESET_OUT;
            acc_d = S_ZERO;
         end
      endcase
   end

   // mode and tick registers
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         state_q  <= pic_pkg::PIC_IDLE;
         cnt_q    <= '0;
         sample_q <= 1'b0;
         run_q    <= 1'b0;
      end else begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         sample_q <= tick;
         run_q    <= (state_d == pic_pkg::PIC_AUTO);
      end
   end

   // latch direction
   // a change while running is simply not taken until the next entry
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         act_q <= pic_pkg::ACT_POSITIVE;
      end else begin
         act_q <= act_eff;
      end
   end

   // controller memory
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         acc_q <= S_ZERO;
         ep_q  <= S_ZERO;
         out_q <= pic_pkg::RESET_OUT;
      end else begin
         acc_q <= acc_d;
         ep_q  <= ep_d;
         out_q <= out_d;
      end
   end

   // outputs come straight from their registers
   assign o_control_output = out_q;
   assign o_sample         = sample_q;
   assign o_running        = run_q;
endmodule // pic_top

// ==== tb/pic_plant.sv ====
/* pic_plant: process fed by the controller output.
   assumes unity process gain and one clock of lag. */
`timescale 1ns/10ps
module pic_plant (
   input  wire logic        [15:0] i_u,
   input  wire logic               i_clk_sys,
   output logic signed      [15:0] o_pv
);
   // process tracks the drive, so a loop can settle
   always_ff @(posedge i_clk_sys) o_pv <= i_u;
endmodule // pic_plant

// ==== tb/pic_checker.sv ====
/* pic_checker: port assertions for pic_top.
   assumes one clock and an active-low synchronous reset. */
`timescale 1ns/10ps
module pic_checker #(
   parameter int SC = 20
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_resetn,
   input  wire logic        i_auto_sel,
   input  wire logic        i_hold_low,
   input  wire logic        o_sample,
   input  wire logic        o_running,
   input  wire logic [15:0] i_manual_level,
   input  wire logic [15:0] o_control_output
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   property p_rng; o_control_output <= 16'h03e8; endproperty
   a_rng: assert property (p_rng) else $error("output range");
   property p_hld; i_hold_low[*3] |-> o_control_output == 16'h0000; endproperty
   a_hld: assert property (p_hld) else $error("hold");
   property p_man; (i_resetn && !i_hold_low && !i_auto_sel && $stable(i_manual_level))[*3]
      |-> o_control_output == i_manual_level; endproperty
   a_man: assert property (p_man) else $error("manual");
   property p_per; o_sample |-> ##SC o_sample; endproperty
   a_per: assert property (p_per) else $error("period");
   property p_gap; o_sample |=> !o_sample[*8]; endproperty
   a_gap: assert property (p_gap) else $error("gap");
   property p_off; (!i_auto_sel || i_hold_low)[*2] |-> !o_running; endproperty
   a_off: assert property (p_off) else $error("off");
   property p_on; (i_resetn && i_auto_sel && !i_hold_low)[*3] |-> o_running; endproperty
   a_on: assert property (p_on) else $error("on");
   property p_ent; $rose(o_running) |-> o_control_output == i_manual_level; endproperty
   a_ent: assert property (p_ent) else $error("entry");
endmodule // pic_checker
bind pic_top pic_checker #(.SC(SAMPLE_CYCLES)) u_chk (.i_clk_sys(i_clk_sys),
   .i_resetn(i_resetn), .i_auto_sel(i_auto_sel), .i_hold_low(i_hold_low),
   .o_sample(o_sample), .o_running(o_running), .i_manual_level(i_manual_level),
   .o_control_output(o_control_output));

// ==== tb/tb.sv ====
/* tb: scenario bench for pic_top with a plant model.
   assumes a 20-cycle tick in place of 500 ms. */
`timescale 1ns/10ps
`define CHK(a,e,m) begin tests_run++; if ((a)!==(e)) begin bad_count++; $display("unexpected %0t %s",$time,m); end end
module tb;
   logic i_clk_sys=0, i_resetn=0, i_auto_sel=0, i_hold_low=0, i_act_positive=1, o_sample, o_running;
   logic [13:0] i_prop_gain=14'h0019;
   logic [6:0] i_period_min=7'h00;
   logic [5:0] i_period_sec=6'h0a;
   logic [15:0] i_manual_level=16'h012c, o_control_output;
   logic signed [15:0] i_setpoint=16'h01f4, i_process_value, i_pv_floor=16'hd8f0;
   logic signed [15:0] i_pv_ceiling=16'h4e20, i_pv_offset=16'h0000;
   logic signed [11:0] i_pv_mult=12'h064;
   logic [1:0] i_decimals=2'h0;
   int bad_count=0, tests_run=0, cyc=0;
   pic_top #(.SAMPLE_CYCLES(20)) uut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
      .i_auto_sel(i_auto_sel), .i_hold_low(i_hold_low), .i_process_value(i_process_value),
      .i_setpoint(i_setpoint), .i_prop_gain(i_prop_gain), .i_period_min(i_period_min),
      .i_period_sec(i_period_sec), .i_act_positive(i_act_positive),
      .i_manual_level(i_manual_level), .i_pv_floor(i_pv_floor), .i_pv_ceiling(i_pv_ceiling),
      .i_pv_mult(i_pv_mult), .i_pv_offset(i_pv_offset), .i_decimals(i_decimals),
      .o_control_output(o_control_output), .o_sample(o_sample), .o_running(o_running));
   pic_plant u_pl (.i_clk_sys(i_clk_sys), .i_u(o_control_output), .o_pv(i_process_value));
   initial forever #5 i_clk_sys = ~i_clk_sys;
   // hang guard, well past the ~1040 cycles needed
   always @(posedge i_clk_sys) if (++cyc > 3000) begin bad_count++; summarize; end
   task summarize; $display("mismatches %0d of %0d", bad_count, tests_run);
      if (bad_count==0 && tests_run>0) $display("TB: PASS"); else $display("TB: FAIL");
      $finish; endtask
   task go(input logic a, input int n); @(negedge i_clk_sys) i_auto_sel=a;
      repeat(n) @(negedge i_clk_sys); endtask
   // sense is changed while still running, then taken at the next entry after the manual spell
   task t_dir(input logic p); i_act_positive=p; go(0,3); go(1,200);
      `CHK(p ? o_control_output>16'h012c : o_control_output<16'h012c, 1'b1, "dir")
      `CHK(o_running, 1'b1, "run")
   endtask
   // one term switched off; the sense set while still running must wait for re-entry
   task t_term(input logic [13:0] g, input logic [6:0] m, input logic [5:0] s);
      i_act_positive=1; i_prop_gain=g; i_period_min=m; i_period_sec=s; go(0,3); go(1,200);
   endtask
   initial begin
      repeat(6) @(negedge i_clk_sys); i_resetn=1;
      go(0,4); `CHK(o_control_output, 16'h012c, "manual")
      i_hold_low=1; go(1,4); `CHK(o_control_output, 16'h0000, "hold")
      i_hold_low=0; t_dir(1);
      t_dir(0);
      t_term(14'h0000, 7'h00, 6'h0a); `CHK(o_control_output>16'h012c, 1'b1, "no p")
      t_term(14'h0019, 7'h63, 6'h3b); `CHK(o_control_output, 16'h012c, "no i")
      i_period_min=7'h00; i_period_sec=6'h0a;
      i_manual_level=16'h01f4; t_dir(1);
      `CHK(o_control_output, 16'h01f4, "equal")
      summarize;
   end
endmodule // tb
